// ---- pkg/icc_pkg.sv ----
package icc_pkg;
    localparam logic [12:0] ADDR_STATUS = 13'h030;
    localparam logic [12:0] ADDR_CONTROL = 13'h031;
    localparam logic [12:0] ADDR_STATIC = 13'h032;
    localparam logic [12:0] ADDR_POWER_DOWN = 13'h04a;
    localparam logic [12:0] ADDR_THR_LOW = 13'h050;
    localparam logic [12:0] ADDR_THR_HIGH = 13'h051;
    localparam logic [12:0] ADDR_HYST = 13'h052;
    localparam logic [12:0] ADDR_AC_HYST = 13'h055;
    localparam logic [12:0] ADDR_AC_THR_LOW = 13'h14f;
    localparam logic [12:0] ADDR_AC_THR_HIGH = 13'h150;
    localparam logic [12:0] ADDR_INIT_FIRST = 13'h060;
    localparam logic [12:0] ADDR_INIT_LAST = 13'h064;
    localparam logic [12:0] ADDR_INDEX = 13'h010;
    localparam logic [7:0] INDEX_EXTENDED = 8'h80;
    localparam int CTRL_ON = 0;
    localparam int CTRL_FREEZE = 1;
    localparam int CTRL_DIS_OFFSET = 2;
    localparam int CTRL_DIS_GAIN = 3;
    localparam int CTRL_DIS_SKEW = 4;
    localparam int CTRL_NOTCH = 5;
    localparam int STAT_SKIP_COARSE = 5;
    localparam int PD_ALGO = 0;
    localparam int PD_NOTCH = 1;
    localparam int STS_LOW_POWER = 0;
    localparam int STS_LOW_AC = 1;
    localparam int STS_SETTLED = 2;
    localparam logic [15:0] THR_RESET = 16'h1000;
    localparam logic [7:0] HYST_RESET = 8'h00;
    localparam logic [15:0] AC_THR_RESET = 16'h1000;
    localparam logic [7:0] INIT_RESET = 8'h80;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATIC_RESET = 8'h00;
    localparam logic [7:0] STATIC_WR_MASK = 8'h61;
    localparam int THR_LSB = 4;
    localparam int CLK_MHZ = 50;
    localparam int WINDOW_NS = 1000;
    localparam int WINDOW_CYCLES = (WINDOW_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_MS = 1000;
    localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int INIT_COUNT = 5;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } icc_cfg_req_s;

    typedef struct packed {
        logic upd_offset;
        logic upd_gain;
        logic upd_skew;
        logic adj_frozen;
        logic notch_use;
        logic coarse_run;
        logic load_init;
    } icc_engine_s;
endpackage

// ---- logic/icc_control.sv ----
// What this block does
// - status bit 0 flags low total power; analog adjustments frozen while set
// - status bit 1 flags low ac power; correction kept, skew updates stopped
// - status bit 2 is zero while settling after start, one when settled
// - poor input puts engine in hold: adjustments frozen, gain and skew estimates stopped
// - control bit 0 turns engine on or off; writable while running
// - control bit 1 freezes all state; clearing it resumes unchanged
// - control bits 2 to 4 disable offset, gain, skew adjustments
// - control bit 5 routes samples through notch filter before estimation
// - static bit 5 skips coarse adjustment at start
// - reference core gain is the target; only other core is adjusted
// - power-down bit 0 stops algorithm, bit 1 stops notch filter
// - square 12-bit samples to 24 bits, average, compare every microsecond
// - 16-bit threshold sits at bits 19..4 of 24-bit word
// - threshold resets to 0x1000; below it the engine freezes
// - total power freeze stops gain and skew updates, not offset
// - leave hold at threshold plus hysteresis, hysteresis at bits 11..4
// - second meter measures power of high-passed samples
// - ac power freeze stops skew updates only
// - ac meter uses its own hysteresis with same placement
// - init registers hold offset, gain, skew starts loaded before minimizing
`timescale 1ns/1ps
module icc_control
    import icc_pkg::*;
#(
    parameter int SAMPLE_BITS = 10,
    parameter int AVG_SAMPLES = WINDOW_CYCLES,
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire icc_cfg_req_s cfg_req,
    output logic [7:0] cfg_rdata,
    input wire logic [SAMPLE_BITS-1:0] sample,
    input wire logic ref_core_sel,
    output icc_engine_s engine,
    output logic [7:0] init_value [INIT_COUNT],
    output logic target_core
);

    ////////////////////////////////////////////////////////////////////////
    // register file

    typedef enum {ST_OFF, ST_COARSE, ST_LOAD, ST_SETTLE, ST_TRACK} icc_state_e;

    logic [7:0] control;
    logic [7:0] static_ctrl;
    logic [7:0] power_down;
    logic [15:0] thr;
    logic [7:0] hyst;
    logic [7:0] ac_hyst;
    logic [15:0] ac_thr;
    logic [7:0] index_reg;
    logic [7:0] init_mem [INIT_COUNT];
    logic low_power;
    logic low_ac;
    logic settled;
    icc_state_e state;
    logic [31:0] settle_cnt;
    logic latched_ref;

    wire wr = cfg_req.wr;
    wire [12:0] a = cfg_req.addr;
    wire ext_sel = (index_reg == INDEX_EXTENDED);
    wire wr_init = wr && a >= ADDR_INIT_FIRST && a <= ADDR_INIT_LAST;
    wire [2:0] init_idx = 3'(a - ADDR_INIT_FIRST);
    wire engine_on = control[CTRL_ON] && !power_down[PD_ALGO];
    wire frozen = control[CTRL_FREEZE];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= CTRL_RESET;
            static_ctrl <= STATIC_RESET;
            power_down <= 8'h00;
            thr <= THR_RESET;
            hyst <= HYST_RESET;
            ac_hyst <= HYST_RESET;
            ac_thr <= AC_THR_RESET;
            index_reg <= 8'h00;
        end else if (wr) begin
            if (a == ADDR_CONTROL) control <= cfg_req.wdata;
            if (a == ADDR_STATIC) static_ctrl <= cfg_req.wdata & STATIC_WR_MASK;
            if (a == ADDR_POWER_DOWN) power_down <= cfg_req.wdata;
            if (a == ADDR_THR_LOW) thr[7:0] <= cfg_req.wdata;
            if (a == ADDR_THR_HIGH) thr[15:8] <= cfg_req.wdata;
            if (a == ADDR_HYST) hyst <= cfg_req.wdata;
            if (a == ADDR_AC_HYST) ac_hyst <= cfg_req.wdata;
            if (a == ADDR_INDEX) index_reg <= cfg_req.wdata;
            // ac threshold only reachable through the extended index
            if (a == ADDR_AC_THR_HIGH && ext_sel) ac_thr[15:8] <= cfg_req.wdata;
            if (a == ADDR_AC_THR_LOW && ext_sel) ac_thr[7:0] <= cfg_req.wdata;
        end
    end

    generate
        for (genvar i = 0; i < INIT_COUNT; i++) begin : g_init
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) init_mem[i] <= INIT_RESET;
                else if (wr_init && init_idx == 3'(i)) init_mem[i] <= cfg_req.wdata;
            end
            assign init_value[i] = init_mem[i];
        end
    endgenerate

    wire [7:0] status_val = {5'h00, settled, low_ac, low_power};
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (a)
            ADDR_STATUS: next_rdata = status_val;
            ADDR_CONTROL: next_rdata = control;
            ADDR_STATIC: next_rdata = static_ctrl;
            ADDR_POWER_DOWN: next_rdata = power_down;
            ADDR_THR_LOW: next_rdata = thr[7:0];
            ADDR_THR_HIGH: next_rdata = thr[15:8];
            ADDR_HYST: next_rdata = hyst;
            ADDR_AC_HYST: next_rdata = ac_hyst;
            ADDR_INDEX: next_rdata = index_reg;
            default: next_rdata = (a >= ADDR_INIT_FIRST && a <= ADDR_INIT_LAST) ?
                init_mem[init_idx] : 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) cfg_rdata <= 8'h00;
        else if (cfg_req.rd) cfg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // power meters

    // samples msb-aligned to 12 bits before squaring
    wire [11:0] s12 = 12'({sample, {(12 - SAMPLE_BITS){1'b0}}});
    wire signed [11:0] ss = $signed(s12);
    logic signed [11:0] prev_s;
    // first difference as a cheap high-pass: a dc level contributes nothing
    wire signed [12:0] diff = 13'(ss) - 13'(prev_s);
    wire signed [11:0] hp = 12'(diff >>> 1);
    wire [23:0] sq = 24'(ss * ss);
    wire [23:0] sq_ac = 24'(hp * hp);

    logic [23:0] avg_total;
    logic [23:0] avg_ac;
    logic window_done;

    icc_meter #(.AVG_SAMPLES(AVG_SAMPLES)) u_meter_total (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sq(sq),
        .enable(engine_on && !frozen),
        .avg(avg_total),
        .done(window_done)
    );

    icc_meter #(.AVG_SAMPLES(AVG_SAMPLES)) u_meter_ac (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sq(sq_ac),
        .enable(engine_on && !frozen),
        .avg(avg_ac),
        .done()
    );

    function automatic logic [23:0] place_thr(input logic [15:0] v);
        place_thr = {4'h0, v, 4'h0};
    endfunction

    function automatic logic [23:0] place_hyst(input logic [7:0] v);
        place_hyst = {12'h000, v, 4'h0};
    endfunction

    wire [24:0] exit_lvl = 25'(place_thr(thr)) + 25'(place_hyst(hyst));
    wire [24:0] ac_exit_lvl = 25'(place_thr(ac_thr)) + 25'(place_hyst(ac_hyst));
    wire next_low = low_power ? (25'(avg_total) < exit_lvl)
        : (avg_total < place_thr(thr));
    wire next_low_ac = low_ac ? (25'(avg_ac) < ac_exit_lvl)
        : (avg_ac < place_thr(ac_thr));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_s <= 12'sh000;
            low_power <= 1'b0;
            low_ac <= 1'b0;
        end else begin
            prev_s <= ss;
            if (!engine_on) begin
                low_power <= 1'b0;
                low_ac <= 1'b0;
            end else if (window_done) begin
                low_power <= next_low;
                low_ac <= next_low_ac;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine sequencer

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            settle_cnt <= 32'h0;
            settled <= 1'b0;
            latched_ref <= 1'b0;
        end else if (!engine_on) begin
            state <= ST_OFF;
            settled <= 1'b0;
        end else if (!frozen) begin
            unique case (state)
                ST_OFF: begin
                    latched_ref <= ref_core_sel;
                    settle_cnt <= 32'h0;
                    state <= static_ctrl[STAT_SKIP_COARSE] ? ST_LOAD : ST_COARSE;
                end
                ST_COARSE: state <= ST_LOAD;
                ST_LOAD: state <= ST_SETTLE;
                ST_SETTLE: begin
                    if (settle_cnt == 32'(SETTLE_COUNT - 1)) begin
                        settled <= 1'b1;
                        state <= ST_TRACK;
                    end else begin
                        settle_cnt <= settle_cnt + 32'h1;
                    end
                end
                ST_TRACK: state <= ST_TRACK;
            endcase
        end
    end

    // limitation: settling here is a fixed count, not input dependent
    wire running = engine_on && (state == ST_SETTLE || state == ST_TRACK) && !frozen;
    wire hold = low_power;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engine <= '0;
            target_core <= 1'b0;
        end else begin
            engine.upd_offset <= running && !control[CTRL_DIS_OFFSET];
            engine.upd_gain <= running && !control[CTRL_DIS_GAIN] && !hold;
            engine.upd_skew <= running && !control[CTRL_DIS_SKEW] && !hold && !low_ac;
            engine.adj_frozen <= frozen || hold || !engine_on;
            engine.notch_use <= control[CTRL_NOTCH] && !power_down[PD_NOTCH];
            engine.coarse_run <= (state == ST_COARSE) && !frozen;
            engine.load_init <= (state == ST_LOAD) && !frozen;
            target_core <= !latched_ref;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////
// averaging power meter

module icc_meter
    import icc_pkg::*;
#(
    parameter int AVG_SAMPLES = WINDOW_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [23:0] sq,
    input wire logic enable,
    output logic [23:0] avg,
    output logic done
);
    localparam int CW = $clog2(AVG_SAMPLES + 1);
    logic [CW-1:0] cnt;
    logic [23+CW:0] acc;
    wire last = cnt == CW'(AVG_SAMPLES - 1);
    wire [23+CW:0] sum = acc + (24+CW)'(sq);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            acc <= '0;
            avg <= '0;
            done <= 1'b0;
        end else begin
            done <= enable && last;
            if (enable) begin
                cnt <= last ? '0 : cnt + CW'(1);
                acc <= last ? '0 : sum;
                if (last) avg <= 24'(sum / (24+CW)'(AVG_SAMPLES));
            end
        end
    end
endmodule

// ---- dv/icc_control_asserts.sv ----
`timescale 1ns/1ps
module icc_control_asserts
    import icc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire icc_cfg_req_s cfg_req,
    input wire logic [7:0] cfg_rdata,
    input wire logic ref_core_sel,
    input wire icc_engine_s engine,
    input wire logic target_core
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // write decodes and update summary shared by several properties
    wire ctrl_wr = cfg_req.wr && cfg_req.addr == ADDR_CONTROL;
    wire stat_wr = cfg_req.wr && cfg_req.addr == ADDR_STATIC;
    wire pd_wr = cfg_req.wr && cfg_req.addr == ADDR_POWER_DOWN;
    wire upd_any = engine.upd_offset || engine.upd_gain || engine.upd_skew;
    ////////////////////////////////////////////////////////////////////////////
    chk_static_masked: assert property (
        stat_wr ##1 cfg_req.rd && cfg_req.addr == ADDR_STATIC
        |=> cfg_rdata == ($past(cfg_req.wdata, 2) & STATIC_WR_MASK))
        else $error("static reserved bits kept");
    chk_ctrl_readback: assert property (
        ctrl_wr ##1 cfg_req.rd && cfg_req.addr == ADDR_CONTROL
        |=> cfg_rdata[5:0] == $past(cfg_req.wdata[5:0], 2))
        else $error("control readback wrong");
    chk_notch_bypass: assert property (
        ctrl_wr && !cfg_req.wdata[CTRL_NOTCH] |-> ##[1:4] !engine.notch_use)
        else $error("notch still in use");
    chk_offset_disable: assert property (
        ctrl_wr && cfg_req.wdata[CTRL_DIS_OFFSET] |-> ##[1:4] !engine.upd_offset)
        else $error("offset update not disabled");
    chk_skew_disable: assert property (
        ctrl_wr && cfg_req.wdata[CTRL_DIS_SKEW] |-> ##[1:4] !engine.upd_skew)
        else $error("skew update not disabled");
    chk_engine_off: assert property (
        ctrl_wr && !cfg_req.wdata[CTRL_ON] |-> ##[1:4] !upd_any)
        else $error("updates after turn off");
    chk_pd_algo: assert property (
        pd_wr && cfg_req.wdata[PD_ALGO] |-> ##[1:4] !upd_any)
        else $error("updates while powered down");
    chk_coarse_once: assert property (
        $rose(engine.coarse_run) |=> !engine.coarse_run [*4])
        else $error("coarse step repeated");
    chk_target_other: assert property (
        engine.coarse_run || engine.load_init |-> ##1 target_core != ref_core_sel)
        else $error("target is reference core");
    chk_low_power_gate: assert property (
        engine.adj_frozen |-> !engine.upd_gain && !engine.upd_skew)
        else $error("gain or skew updating in low power");
endmodule

bind icc_control icc_control_asserts chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .ref_core_sel(ref_core_sel),
    .engine(engine), .target_core(target_core));

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
    import icc_pkg::*;
    localparam int AVG = 8;
    localparam int SETTLE = 20;
    localparam logic [12:0] RA [10] = '{ADDR_STATUS, ADDR_CONTROL, ADDR_STATIC,
        ADDR_POWER_DOWN, ADDR_INDEX, ADDR_THR_LOW, ADDR_THR_HIGH, ADDR_HYST, ADDR_AC_HYST,
        ADDR_INIT_LAST};
    localparam logic [7:0] RE [10] = '{8'h00, CTRL_RESET, STATIC_RESET, 8'h00, 8'h00,
        THR_RESET[7:0], THR_RESET[15:8], HYST_RESET, HYST_RESET, INIT_RESET};
    // power is 16*amp^2 vs 0x10000; 65 sits inside the 0xff0 hysteresis band
    localparam logic signed [9:0] PA [5] = '{10'sd256, 10'sd64, 10'sd63, 10'sd65, 10'sd66};
    localparam logic [7:0] PE [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    icc_cfg_req_s cfg_req = '0;
    logic [7:0] cfg_rdata;
    logic [9:0] sample = '0;
    logic ref_core_sel = 1'b0;
    icc_engine_s engine;
    logic [7:0] init_value [INIT_COUNT];
    logic target_core;
    logic signed [9:0] amp = '0;
    logic dc = 1'b0;
    logic ph = 1'b0;
    logic seen;
    logic seen_load;
    int bad_count = 0;
    int n_tests = 0;

    always #10 core_clk = ~core_clk;
    // alternating sign keeps high-passed power equal to total; dc removes it
    always @(posedge core_clk) begin
        #1;
        ph = ~ph;
        sample = (dc || ph) ? amp : -amp;
    end

    icc_control #(.SAMPLE_BITS(10), .AVG_SAMPLES(AVG), .SETTLE_COUNT(SETTLE)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .sample(sample), .ref_core_sel(ref_core_sel), .engine(engine),
        .init_value(init_value), .target_core(target_core));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request stays up one edge; the next call replaces it, so back to back works
    task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
        cfg_req = '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        #1;
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        check(cfg_rdata & m, e);
    endtask
    task automatic idle(input int n);
        cfg_req = '0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic ctl(input logic [12:0] a, input logic [7:0] d, input int n);
        xfer(1'b1, a, d);
        idle(n);
    endtask
    function automatic logic [7:0] upd();
        return {5'h00, engine.upd_skew, engine.upd_gain, engine.upd_offset};
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        idle(1);
        for (int i = 0; i < 10; i++) rdc(RA[i], 8'hff, RE[i]);
        for (int i = 0; i < INIT_COUNT; i++) begin
            xfer(1'b1, ADDR_INIT_FIRST + 13'(i), 8'h10 + 8'(i));
            rdc(ADDR_INIT_FIRST + 13'(i), 8'hff, 8'h10 + 8'(i));
        end
        idle(1);
        for (int i = 0; i < INIT_COUNT; i++) check(init_value[i], 8'h10 + 8'(i));
        xfer(1'b1, ADDR_HYST, 8'hff);
        rdc(ADDR_HYST, 8'hff, 8'hff);
        xfer(1'b1, ADDR_AC_HYST, 8'hff);
        rdc(ADDR_AC_HYST, 8'hff, 8'hff);
        xfer(1'b1, ADDR_STATIC, 8'hff);
        rdc(ADDR_STATIC, 8'hff, STATIC_WR_MASK);
        rdc(13'h0ff, 8'hff, 8'h00);
        for (int k = 0; k < 2; k++) begin
            ref_core_sel = k[0];
            ctl(ADDR_STATIC, k[0] ? 8'h20 : 8'h00, 1);
            xfer(1'b1, ADDR_CONTROL, 8'h01);
            seen = 1'b0;
            seen_load = 1'b0;
            for (int c = 0; c < 8; c++) begin
                idle(1);
                seen = seen | engine.coarse_run;
                seen_load = seen_load | engine.load_init;
            end
            check({7'h00, seen_load}, 8'h01);
            check({7'h00, seen}, {7'h00, !k[0]});
            check({7'h00, target_core}, {7'h00, !k[0]});
            ctl(ADDR_CONTROL, 8'h00, 4);
        end
        amp = 10'sd256;
        ctl(ADDR_CONTROL, 8'h01, 4);
        ctl(ADDR_CONTROL, 8'h03, 3 * SETTLE);
        rdc(ADDR_STATUS, 8'h04, 8'h00);
        ctl(ADDR_CONTROL, 8'h01, SETTLE / 2);
        rdc(ADDR_STATUS, 8'h04, 8'h00);
        idle(SETTLE);
        rdc(ADDR_STATUS, 8'h04, 8'h04);
        for (int i = 0; i < 5; i++) begin
            amp = PA[i];
            idle(6 * AVG);
            rdc(ADDR_STATUS, 8'h01, PE[i]);
            check({7'h00, engine.adj_frozen}, PE[i]);
        end
        dc = 1'b1;
        amp = 10'sd256;
        idle(6 * AVG);
        rdc(ADDR_STATUS, 8'h03, 8'h02);
        check(upd(), 8'h03);
        dc = 1'b0;
        amp = 10'sd90;
        // without the index value the extended threshold must not change
        ctl(ADDR_AC_THR_HIGH, 8'h20, 6 * AVG);
        rdc(ADDR_STATUS, 8'h03, 8'h00);
        amp = 10'sd64;
        xfer(1'b1, ADDR_INDEX, INDEX_EXTENDED);
        xfer(1'b1, ADDR_AC_THR_HIGH, 8'h20);
        ctl(ADDR_AC_THR_LOW, 8'h00, 6 * AVG);
        rdc(ADDR_STATUS, 8'h03, 8'h02);
        amp = 10'sd91;
        idle(6 * AVG);
        rdc(ADDR_STATUS, 8'h03, 8'h02);
        amp = 10'sd92;
        idle(6 * AVG);
        rdc(ADDR_STATUS, 8'h03, 8'h00);
        amp = 10'sd256;
        for (int b = 0; b < 3; b++) begin
            ctl(ADDR_CONTROL, 8'h01 | (8'h04 << b), 6 * AVG);
            check(upd(), 8'h07 & ~(8'h01 << b));
        end
        xfer(1'b1, ADDR_CONTROL, 8'h21);
        rdc(ADDR_CONTROL, 8'hff, 8'h21);
        idle(6);
        check({7'h00, engine.notch_use}, 8'h01);
        ctl(ADDR_POWER_DOWN, 8'h02, 6);
        check({7'h00, engine.notch_use}, 8'h00);
        ctl(ADDR_POWER_DOWN, 8'h01, 6);
        check(upd(), 8'h00);
        ctl(ADDR_POWER_DOWN, 8'h00, 6);
        check(upd(), 8'h07);
        ctl(ADDR_CONTROL, 8'h00, 6);
        check(upd(), 8'h00);
        rdc(ADDR_STATUS, 8'h03, 8'h00);
        conclude();
    end
endmodule
